//--- pis_pkg.sv
package pis_pkg;

  // Register indices (word addresses); byte address is four times these
  localparam logic [7:0] PIS_IDX_PWM_SRC = 8'h18;
  localparam logic [7:0] PIS_IDX_DAC_SRC = 8'h19;
  localparam logic [7:0] PIS_IDX_TMR_SRC = 8'h1A;
  localparam logic [7:0] PIS_IDX_PINFUNC = 8'h1B;

  // Field positions
  localparam int PIS_POS_PWM_FAULT_INPUT_TWO = 13;
  localparam int PIS_POS_PWM_FAULT_INPUT_ONE = 11;
  localparam int PIS_POS_PAIR45 = 6;
  localparam int PIS_POS_PAIR23 = 3;
  localparam int PIS_POS_PAIR01 = 0;
  localparam int PIS_POS_DAC1   = 4;
  localparam int PIS_POS_DAC0   = 0;
  localparam int PIS_POS_TIN3   = 12;
  localparam int PIS_POS_TIN2   = 8;
  localparam int PIS_POS_TIN1   = 4;
  localparam int PIS_POS_PB7    = 0;

  // Writable bit masks; other bits read zero
  localparam logic [15:0] PIS_MASK_PWM_SRC = 16'h29FF;
  localparam logic [15:0] PIS_MASK_DAC_SRC = 16'h0077;
  localparam logic [15:0] PIS_MASK_TMR_SRC = 16'h1110;
  localparam logic [15:0] PIS_MASK_PINFUNC = 16'h0001;

  // Reset values
  localparam logic [15:0] PIS_RST_PWM_SRC = 16'h0000;
  localparam logic [15:0] PIS_RST_DAC_SRC = 16'h0000;
  localparam logic [15:0] PIS_RST_TMR_SRC = 16'h0000;
  localparam logic [15:0] PIS_RST_PINFUNC = 16'h0000;

  // Pair source encodings
  localparam logic [2:0] PIS_PAIR_PIN  = 3'h0;
  localparam logic [2:0] PIS_PAIR_TMR  = 3'h1;
  localparam logic [2:0] PIS_PAIR_ADC  = 3'h2;
  localparam logic [2:0] PIS_PAIR_CMPA = 3'h3;
  localparam logic [2:0] PIS_PAIR_CMPB = 3'h4;

  // DAC sync encodings
  localparam logic [2:0] PIS_DSYNC_PIT  = 3'h0;
  localparam logic [2:0] PIS_DSYNC_PWM  = 3'h3;
  localparam logic [2:0] PIS_DSYNC_TMR0 = 3'h4;
  localparam logic [2:0] PIS_DSYNC_TMR1 = 3'h5;

  localparam logic [1:0] PIS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PIS_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {PIS_W_IDLE, PIS_W_RESP} pis_wstate_t;

endpackage

//--- pis_select.sv
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module pis_select
  import pis_pkg::*;
#(
  parameter int ADC_W = 12
)(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              serial0_transmit_line,
  input  wire logic              i2c_scl_out,
  output logic                   port_b_pin7_out,
  input  wire logic              pwm_fault_input_one_pin,
  input  wire logic              pwm_fault_input_two_pin,
  input  wire logic              comparator_a_output,
  input  wire logic              comparator_b_output,
  output logic                   pwm_fault_input_one,
  output logic                   pwm_fault_input_two,
  input  wire logic [2:0]        pair_source_pin,
  input  wire logic              timer_a_channel0,
  input  wire logic              timer_a_channel1,
  input  wire logic              timer_a_channel2,
  input  wire logic              timer_a_channel3,
  input  wire logic [ADC_W-1:0]  adc_result_slot0,
  input  wire logic [ADC_W-1:0]  adc_result_slot1,
  input  wire logic [ADC_W-1:0]  adc_result_slot2,
  input  wire logic [ADC_W-1:0]  high_limit_0,
  input  wire logic [ADC_W-1:0]  high_limit_1,
  input  wire logic [ADC_W-1:0]  high_limit_2,
  input  wire logic [ADC_W-1:0]  low_limit_0,
  input  wire logic [ADC_W-1:0]  low_limit_1,
  input  wire logic [ADC_W-1:0]  low_limit_2,
  output logic                   pair01_source_input,
  output logic                   pair23_source_input,
  output logic                   pair45_source_input,
  output logic [5:0]             pwm_pair_compare,
  input  wire logic              interval_timer_zero,
  input  wire logic              pwm_reload_sync,
  output logic                   dac0_sync,
  output logic                   dac1_sync,
  input  wire logic [3:1]        timer_pin,
  output logic [3:1]             timer_input
);

  typedef struct packed {
    pis_wstate_t  wst;
    logic [7:0]   waddr;
    logic         have_aw;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    logic         have_w;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
    logic [15:0]  pwm_src;
    logic [15:0]  dac_src;
    logic [15:0]  tmr_src;
    logic [15:0]  pinfunc;
    logic [5:0]   cmp;
    logic [2:0]   pins_s1;
    logic [2:0]   pins_s2;
    logic [1:0]   flt_s1;
    logic [1:0]   flt_s2;
    logic [3:1]   tpin_s1;
    logic [3:1]   tpin_s2;
  } pis_state_t;

  pis_state_t st;
  pis_state_t next_st;

  // Word index from a byte address; unaligned low bits ignored
  function automatic logic [5:0] pis_index(input logic [7:0] a);
    return a[7:2];
  endfunction

  // Masked read of a register, unmapped flagged
  function automatic logic [16:0] pis_read(input pis_state_t s,
                                           input logic [5:0] idx);
    logic [16:0] r;
    r = {1'b0, 16'h0000};
    unique case ({2'h0, idx})
      PIS_IDX_PWM_SRC: r = {1'b0, s.pwm_src & PIS_MASK_PWM_SRC};
      PIS_IDX_DAC_SRC: r = {1'b0, s.dac_src & PIS_MASK_DAC_SRC};
      PIS_IDX_TMR_SRC: r = {1'b0, s.tmr_src & PIS_MASK_TMR_SRC};
      PIS_IDX_PINFUNC: r = {1'b0, s.pinfunc & PIS_MASK_PINFUNC};
      default:         r = {1'b1, 16'h0000};
    endcase
    return r;
  endfunction

  // Byte-lane merge into a masked 16-bit register
  function automatic logic [15:0] pis_merge(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  be,
                                            input logic [15:0] m);
    logic [15:0] v;
    v = old;
    if (be[0])
      v[7:0] = d[7:0];
    if (be[1])
      v[15:8] = d[15:8];
    return v & m;
  endfunction

  // One pair's ADC limit compare; holds between limits
  function automatic logic [1:0] pis_cmp(input logic [1:0] prev,
                                         input logic [ADC_W-1:0] smp,
                                         input logic [ADC_W-1:0] hi,
                                         input logic [ADC_W-1:0] lo);
    logic [1:0] v;
    // between limits the old drive stays
    v = prev;
    if (smp > hi)
      v = 2'b10;              // even 0, odd 1
    else if (smp < lo)
      v = 2'b01;              // even 1, odd 0
    return v;
  endfunction

  // Pair source multiplexer; reserved codes give 0
  function automatic logic pis_pair(input logic [2:0] sel,
                                    input logic pin,
                                    input logic tmr,
                                    input logic adc,
                                    input logic ca,
                                    input logic cb);
    logic v;
    v = 1'b0;
    unique case (sel)
      PIS_PAIR_PIN:  v = pin;
      PIS_PAIR_TMR:  v = tmr;
      PIS_PAIR_ADC:  v = adc;
      PIS_PAIR_CMPA: v = ca;
      PIS_PAIR_CMPB: v = cb;
      default:       v = 1'b0;
    endcase
    return v;
  endfunction

  // DAC sync multiplexer; reserved codes give 0
  function automatic logic pis_dsync(input logic [2:0] sel,
                                     input logic pit,
                                     input logic psync,
                                     input logic tmr0,
                                     input logic tmr1);
    logic v;
    v = 1'b0;
    unique case (sel)
      PIS_DSYNC_PIT: v = pit;
      PIS_DSYNC_PWM: v = psync;
      PIS_DSYNC_TMR0: v = tmr0;
      PIS_DSYNC_TMR1: v = tmr1;
      default:       v = 1'b0;
    endcase
    return v;
  endfunction

  logic [16:0] rd;
  logic        wr_go;
  logic [16:0] wr_chk;
  logic [2:0]  p45;
  logic [2:0]  p23;
  logic [2:0]  p01;

  assign p45 = st.pwm_src[PIS_POS_PAIR45 +: 3];
  assign p23 = st.pwm_src[PIS_POS_PAIR23 +: 3];
  assign p01 = st.pwm_src[PIS_POS_PAIR01 +: 3];

  // Bus handshakes; capture slots stay open until filled
  assign s_axi_awready = (st.wst == PIS_W_IDLE) && !st.have_aw;
  assign s_axi_wready  = (st.wst == PIS_W_IDLE) && !st.have_w;
  assign s_axi_bvalid  = (st.wst == PIS_W_RESP);
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;

  assign wr_go  = st.have_aw && st.have_w && (st.wst == PIS_W_IDLE);
  assign rd     = pis_read(st, pis_index(s_axi_araddr));
  assign wr_chk = pis_read(st, pis_index(st.waddr));

  // Next-state logic: bus slave, registers, compare state
  always_comb
  begin
    next_st = st;
    next_st.pins_s1 = pair_source_pin;
    next_st.pins_s2 = st.pins_s1;
    // Fault and timer pins are asynchronous too; two flops each
    next_st.flt_s1  = {pwm_fault_input_two_pin, pwm_fault_input_one_pin};
    next_st.flt_s2  = st.flt_s1;
    next_st.tpin_s1 = timer_pin;
    next_st.tpin_s2 = st.tpin_s1;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_st.waddr   = s_axi_awaddr;
      next_st.have_aw = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_st.wdata  = s_axi_wdata;
      next_st.wstrb  = s_axi_wstrb;
      next_st.have_w = 1'b1;
    end
    if (wr_go)
    begin
      next_st.have_aw = 1'b0;
      next_st.have_w  = 1'b0;
      next_st.wst     = PIS_W_RESP;
      next_st.bresp   = wr_chk[16] ? PIS_RESP_SLVERR : PIS_RESP_OKAY;
      unique case ({2'h0, pis_index(st.waddr)})
        PIS_IDX_PWM_SRC: next_st.pwm_src = pis_merge(st.pwm_src,
                           st.wdata, st.wstrb, PIS_MASK_PWM_SRC);
        PIS_IDX_DAC_SRC: next_st.dac_src = pis_merge(st.dac_src,
                           st.wdata, st.wstrb, PIS_MASK_DAC_SRC);
        PIS_IDX_TMR_SRC: next_st.tmr_src = pis_merge(st.tmr_src,
                           st.wdata, st.wstrb, PIS_MASK_TMR_SRC);
        PIS_IDX_PINFUNC: next_st.pinfunc = pis_merge(st.pinfunc,
                           st.wdata, st.wstrb, PIS_MASK_PINFUNC);
        default:         next_st.bresp = PIS_RESP_SLVERR;
      endcase
    end
    if (st.wst == PIS_W_RESP && s_axi_bready)
      next_st.wst = PIS_W_IDLE;
    // Read returns masked value, reserved bits zero
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = {16'h0000, rd[15:0]};
      next_st.rresp  = rd[16] ? PIS_RESP_SLVERR : PIS_RESP_OKAY;
    end
    else if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;
    next_st.cmp[5:4] = pis_cmp(st.cmp[5:4], adc_result_slot2,
                               high_limit_2, low_limit_2);
    next_st.cmp[3:2] = pis_cmp(st.cmp[3:2], adc_result_slot1,
                               high_limit_1, low_limit_1);
    next_st.cmp[1:0] = pis_cmp(st.cmp[1:0], adc_result_slot0,
                               high_limit_0, low_limit_0);
  end

  // State register; every field cleared on reset
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st         <= '0;
      st.wst     <= PIS_W_IDLE;
      st.pwm_src <= PIS_RST_PWM_SRC;
      st.dac_src <= PIS_RST_DAC_SRC;
      st.tmr_src <= PIS_RST_TMR_SRC;
      st.pinfunc <= PIS_RST_PINFUNC;
    end
    else
      st <= next_st;
  end

  assign pwm_pair_compare = st.cmp;

  assign port_b_pin7_out = st.pinfunc[PIS_POS_PB7] ? i2c_scl_out
                                                   : serial0_transmit_line;

  // fault two source; pin path trades two cycles for safety
  assign pwm_fault_input_two = st.pwm_src[PIS_POS_PWM_FAULT_INPUT_TWO] ?
                               comparator_b_output : st.flt_s2[1];
  assign pwm_fault_input_one = st.pwm_src[PIS_POS_PWM_FAULT_INPUT_ONE] ?
                               comparator_a_output : st.flt_s2[0];

  // pair 4/5 source; code 000 is reserved
  assign pair45_source_input = (p45 == PIS_PAIR_PIN) ? 1'b0 :
    pis_pair(p45, st.pins_s2[2], timer_a_channel3, st.cmp[5],
             comparator_a_output, comparator_b_output);
  assign pair23_source_input = pis_pair(p23, st.pins_s2[1],
    timer_a_channel2, st.cmp[3], comparator_a_output, comparator_b_output);
  assign pair01_source_input = pis_pair(p01, st.pins_s2[0],
    timer_a_channel0, st.cmp[1], comparator_a_output, comparator_b_output);

  assign dac1_sync = pis_dsync(st.dac_src[PIS_POS_DAC1 +: 3],
    interval_timer_zero, pwm_reload_sync, timer_a_channel0,
    timer_a_channel1);
  assign dac0_sync = pis_dsync(st.dac_src[PIS_POS_DAC0 +: 3],
    interval_timer_zero, pwm_reload_sync, timer_a_channel0,
    timer_a_channel1);

  assign timer_input[3] = st.tmr_src[PIS_POS_TIN3] ? pwm_reload_sync
                                                   : st.tpin_s2[3];
  assign timer_input[2] = st.tmr_src[PIS_POS_TIN2] ? comparator_b_output
                                                   : st.tpin_s2[2];
  assign timer_input[1] = st.tmr_src[PIS_POS_TIN1] ? comparator_a_output
                                                   : st.tpin_s2[1];

endmodule

`default_nettype wire

//--- pis_select_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pis_select_chk
  import pis_pkg::*;
#(
  parameter int ADC_W = 12
)(
  input wire logic             core_clk,
  input wire logic             rst_n,
  input wire logic [7:0]       s_axi_araddr,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic [1:0]       s_axi_rresp,
  input wire logic             s_axi_rvalid,
  input wire logic [ADC_W-1:0] adc_result_slot0,
  input wire logic [ADC_W-1:0] adc_result_slot1,
  input wire logic [ADC_W-1:0] adc_result_slot2,
  input wire logic [ADC_W-1:0] high_limit_0,
  input wire logic [ADC_W-1:0] high_limit_1,
  input wire logic [ADC_W-1:0] low_limit_0,
  input wire logic [ADC_W-1:0] low_limit_2,
  input wire logic [5:0]       pwm_pair_compare
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Read address taken in the same cycle as an address outside the four mapped words
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rd_unmapped;
    rd_take ##0 (s_axi_araddr[7:2] < 6'h18 || s_axi_araddr[7:2] > 6'h1B);
  endsequence
  // Compare drive follows the limits one cycle later
  a_pair01_above: assert property (
    adc_result_slot0 > high_limit_0 |=> pwm_pair_compare[1:0] == 2'b10)
    else $error("pair01 above limit wrong");
  a_pair01_below: assert property (
    adc_result_slot0 < low_limit_0 |=> pwm_pair_compare[1:0] == 2'b01)
    else $error("pair01 below limit wrong");
  a_pair01_hold: assert property (
    adc_result_slot0 <= high_limit_0 && adc_result_slot0 >= low_limit_0
    |=> $stable(pwm_pair_compare[1:0]))
    else $error("pair01 not held between limits");
  a_pair23_above: assert property (
    adc_result_slot1 > high_limit_1 |=> pwm_pair_compare[3:2] == 2'b10)
    else $error("pair23 above limit wrong");
  a_pair45_below: assert property (
    adc_result_slot2 < low_limit_2 |=> pwm_pair_compare[5:4] == 2'b01)
    else $error("pair45 below limit wrong");
  // Reset must override the default disable to be seen at all
  a_reset_clear: assert property (disable iff (1'b0)
    !rst_n |=> pwm_pair_compare == 6'h00 && !s_axi_rvalid)
    else $error("outputs not cleared by reset");
  a_rd_unmapped: assert property (
    rd_unmapped |=> s_axi_rresp == PIS_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_rd_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
endmodule
bind pis_select pis_select_chk #(.ADC_W(ADC_W)) u_chk (
  .core_clk, .rst_n, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .adc_result_slot0,
  .adc_result_slot1, .adc_result_slot2, .high_limit_0, .high_limit_1,
  .low_limit_0, .low_limit_2, .pwm_pair_compare
);
`default_nettype wire

//--- pis_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module pis_periph_model (
  input  wire logic        core_clk,
  input  wire logic [17:0] pat,
  input  wire logic [11:0] smp,
  output logic      [17:0] src,
  output logic      [11:0] adc
);
  // one pin per input
  // Peripherals launch new values just after the edge
  always_ff @(posedge core_clk)
  begin
    src <= pat;
    adc <= smp;
  end
endmodule
`default_nettype wire

//--- tb_pis_select.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("ERROR %0t: got %h exp %h", $time, got, exp); \
    end \
  end
module tb_pis_select;
  import pis_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [17:0] pat = 18'h0;
  logic [11:0] smp = 12'h000;
  logic [11:0] hi = 12'hFFF;
  logic [11:0] lo = 12'h000;
  logic [17:0] src;
  logic [11:0] adc;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bresp_seen;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, port_b_pin7_out;
  logic        pwm_fault_input_one, pwm_fault_input_two, dac0_sync;
  logic        pair01_source_input, pair23_source_input, dac1_sync;
  logic        pair45_source_input;
  logic [5:0]  pwm_pair_compare;
  logic [3:1]  timer_input;
  int          fail_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  // Every single-bit mux output, indexed by the scenario table
  wire logic [10:0] obs = {timer_input, dac1_sync, dac0_sync,
    pair45_source_input, pair23_source_input, pair01_source_input,
    pwm_fault_input_two, pwm_fault_input_one, port_b_pin7_out};

  pis_periph_model u_periph (.core_clk, .pat, .smp, .src, .adc);
  pis_select dut (
    .core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .serial0_transmit_line(src[0]),
    .i2c_scl_out(src[1]), .port_b_pin7_out, .pwm_fault_input_one_pin(src[2]),
    .pwm_fault_input_two_pin(src[3]), .comparator_a_output(src[4]),
    .comparator_b_output(src[5]), .pwm_fault_input_one,
    .pwm_fault_input_two, .pair_source_pin(src[8:6]),
    .timer_a_channel0(src[9]), .timer_a_channel1(src[10]),
    .timer_a_channel2(src[11]), .timer_a_channel3(src[12]),
    .adc_result_slot0(adc), .adc_result_slot1(adc),
    .adc_result_slot2(adc), .high_limit_0(hi), .high_limit_1(hi),
    .high_limit_2(hi), .low_limit_0(lo), .low_limit_1(lo),
    .low_limit_2(lo), .pair01_source_input, .pair23_source_input,
    .pair45_source_input, .pwm_pair_compare,
    .interval_timer_zero(src[13]), .pwm_reload_sync(src[14]),
    .dac0_sync, .dac1_sync, .timer_pin(src[17:15]), .timer_input
  );

  // Clock, 25 ns period
  always #12.5 core_clk = ~core_clk;

  // Ready is sampled at the falling edge so no race with the design
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic done;
    logic ra;
    logic rw;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done)
    begin
      @(negedge core_clk);
      ra = s_axi_awready;
      rw = s_axi_wready;
      done = s_axi_bvalid;
      bresp_seen = s_axi_bresp;
      @(posedge core_clk);
      if (ra)
        s_axi_awvalid <= 1'b0;
      if (rw)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask

  // Read one word and judge data and response
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic done;
    logic ra;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done)
    begin
      @(negedge core_clk);
      ra = s_axi_arready;
      done = s_axi_rvalid;
      if (done)
      begin
        `CHK(s_axi_rdata, e)
        `CHK(s_axi_rresp, er)
      end
      @(posedge core_clk);
      if (ra)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask

  // Reset values, reserved bits, byte strobes, unmapped word
  task automatic regs();
    logic [15:0] msk [4];
    msk = '{16'h29FF, 16'h0077, 16'h1110, 16'h0001};
    for (int k = 0; k < 4; k++)
    begin
      rc(8'h60 + 8'(4 * k), 32'h0, PIS_RESP_OKAY);
      wr(8'h60 + 8'(4 * k), 16'hFFFF);
      `CHK(bresp_seen, PIS_RESP_OKAY)
      rc(8'h60 + 8'(4 * k), {16'h0000, msk[k]}, PIS_RESP_OKAY);
      wr(8'h60 + 8'(4 * k), 16'h0000);
    end
    s_axi_wstrb <= 4'h1;
    wr(8'h60, 16'hFFFF);
    s_axi_wstrb <= 4'hF;
    rc(8'h60, 32'h000000FF, PIS_RESP_OKAY);
    wr(8'h70, 16'hFFFF);
    `CHK(bresp_seen, PIS_RESP_SLVERR)
    rc(8'h70, 32'h0, PIS_RESP_SLVERR);
  endtask

  // Row: address, data, output index, source bit (FF means none)
  task automatic mux(input logic [39:0] q[$]);
    logic [17:0] pv;
    foreach (q[i])
    begin
      wr(q[i][39:32], q[i][31:16]);
      pv = (q[i][7:0] == 8'hFF) ? 18'h3FFFF : 18'h00001 << q[i][4:0];
      for (int k = 0; k < 2; k++)
      begin
        pat <= k ? ~pv : pv;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        `CHK(obs[q[i][11:8]], k == 0 && q[i][7:0] != 8'hFF)
        @(posedge core_clk);
      end
    end
  endtask

  // Shared sample against limits, boundaries must hold
  task automatic acmp(input logic [11:0] v, input logic [5:0] e);
    smp <= v;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    `CHK(pwm_pair_compare, e)
    `CHK({pair45_source_input, pair23_source_input, pair01_source_input}, {e[5], e[3], e[1]})
    @(posedge core_clk);
  endtask

  // Mid-run reset must clear every select and compare drive
  task automatic mid_reset();
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    `CHK(pwm_pair_compare, 6'h00)
    @(posedge core_clk);
    for (int k = 0; k < 4; k++)
      rc(8'h60 + 8'(4 * k), 32'h0, PIS_RESP_OKAY);
  endtask

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard, far beyond the several hundred cycles needed
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      print_verdict();
    end
  end

  // Main sequence
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    regs();
    mux('{40'h6C_0000_00_00, 40'h6C_0001_00_01});
    mux('{40'h60_0000_01_02, 40'h60_0800_01_04});
    mux('{40'h60_0000_02_03, 40'h60_2000_02_05});
    mux('{40'h60_0000_03_06, 40'h60_0001_03_09, 40'h60_0003_03_04,
          40'h60_0004_03_05, 40'h60_0007_03_FF});
    mux('{40'h60_0000_04_07, 40'h60_0008_04_0B, 40'h60_0018_04_04,
          40'h60_0020_04_05, 40'h60_0030_04_FF});
    mux('{40'h60_0000_05_FF, 40'h60_0040_05_0C, 40'h60_00C0_05_04,
          40'h60_0100_05_05, 40'h60_0140_05_FF});
    mux('{40'h64_0000_06_0D, 40'h64_0003_06_0E, 40'h64_0004_06_09,
          40'h64_0005_06_0A, 40'h64_0001_06_FF});
    mux('{40'h64_0000_07_0D, 40'h64_0030_07_0E, 40'h64_0040_07_09,
          40'h64_0050_07_0A, 40'h64_0020_07_FF});
    mux('{40'h68_0000_08_0F, 40'h68_0010_08_04, 40'h68_0000_09_10,
          40'h68_0100_09_05, 40'h68_0000_0A_11, 40'h68_1000_0A_0E});
    wr(8'h60, 16'h0092);
    hi <= 12'h800;
    lo <= 12'h400;
    acmp(12'h900, 6'h2A);
    acmp(12'h800, 6'h2A);
    acmp(12'h100, 6'h15);
    acmp(12'h400, 6'h15);
    acmp(12'h600, 6'h15);
    mid_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
